// >>> hdl/apd_consts.svh
// Offsets, field positions, reset values and timing counts of the power-down control block
// Assumes a 250 MHz converter clock and 32-bit AXI4-Lite register access
`ifndef APD_CONSTS_SVH
`define APD_CONSTS_SVH

`define APD_ADDR_W 12
`define APD_DATA_W 32
`define APD_CH_N 8

`define APD_OFS_CTRL 12'h000
`define APD_OFS_FA_MASK 12'h004
`define APD_OFS_CV_MASK 12'h008
`define APD_OFS_STATUS 12'h00c

`define APD_CTRL_FA_FAST 0
`define APD_CTRL_FA_FULL 1
`define APD_CTRL_CV_FAST 2
`define APD_CTRL_CV_FULL 3
`define APD_CTRL_ATT_OFF 4
`define APD_CTRL_LNA_OFF 5

`define APD_ST_FA_READY 0
`define APD_ST_CV_READY 1
`define APD_ST_REF_OFF 2
`define APD_ST_SER_OFF 3
`define APD_ST_RELOAD 4

`define APD_CTRL_RST 6'h00
`define APD_MASK_RST 8'h00

`define APD_CLK_MHZ 250
`define APD_FA_WAKE_NS 2000
`define APD_CV_WAKE_NS 1000
`define APD_FA_WAKE_CYC ((`APD_FA_WAKE_NS * `APD_CLK_MHZ + 999) / 1000)
`define APD_CV_WAKE_CYC ((`APD_CV_WAKE_NS * `APD_CLK_MHZ + 999) / 1000)
`define APD_PCT_DIV 100

`define APD_RESP_OKAY 2'h0
`define APD_RESP_SLVERR 2'h2

`endif

// >>> hdl/apd_pkg.sv
// Types of the power-down control block
// Assumes apd_consts.svh supplies the widths
`include "apd_consts.svh"
package apd_pkg;
	typedef struct packed {
		logic [`APD_ADDR_W-1:0] awaddr;
		logic awvalid;
		logic [`APD_DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [`APD_ADDR_W-1:0] araddr;
		logic arvalid;
		logic rready;
	} apd_axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [`APD_DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} apd_axil_rsp_t;

	typedef struct packed {
		logic input_amp_off_bit;
		logic attenuator_gain_stage_off_bit;
		logic converter_full_off_bit;
		logic converter_fast_sleep_bit;
		logic front_amp_full_off_bit;
		logic front_amp_fast_sleep_bit;
	} apd_ctrl_t;
endpackage

// >>> hdl/apd_wake_timer.sv
// Wake-up timer: ready rises after the larger of a fixed time or a percent of the sleep time
// Assumes sleep is a synchronous level in the clock domain
`timescale 1ns/1ps
`include "apd_consts.svh"
module apd_wake_timer #(
	parameter int CNT_W = 24,
	parameter logic [CNT_W-1:0] MIN_CYC = CNT_W'(`APD_FA_WAKE_CYC),
	parameter bit PCT_EN = 1'b1,
	parameter logic [6:0] PCT_DIV = 7'(`APD_PCT_DIV)
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic sleep,
	output logic ready
);
	logic [6:0] prescale_ff;
	logic [CNT_W-1:0] pct_ff;
	logic [CNT_W-1:0] wait_ff;
	logic sleep_q_ff;
	logic ready_ff;
	wire entering = sleep & ~sleep_q_ff;
	wire leaving = ~sleep & sleep_q_ff;
	wire pct_tick = sleep & (prescale_ff == PCT_DIV - 7'h01);
	wire pct_max = &pct_ff;
	wire [CNT_W-1:0] load = (PCT_EN && (pct_ff > MIN_CYC)) ? pct_ff : MIN_CYC;
	wire [6:0] nxt_prescale = (~sleep | pct_tick) ? 7'h00 : prescale_ff + 7'h01;
	wire [CNT_W-1:0] nxt_pct = entering ? '0 : ((pct_tick & ~pct_max) ? pct_ff + 1'b1 : pct_ff);
	wire [CNT_W-1:0] nxt_wait = sleep ? '0 : (leaving ? load - 1'b1 : ((wait_ff != '0) ? wait_ff - 1'b1 : '0));
	wire nxt_ready = ~sleep & ~leaving & (wait_ff == '0);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			prescale_ff <= 7'h00;
			pct_ff <= '0;
			wait_ff <= '0;
			sleep_q_ff <= 1'b0;
			ready_ff <= 1'b0;
		end else begin
			prescale_ff <= nxt_prescale;
			pct_ff <= nxt_pct;
			wait_ff <= nxt_wait;
			sleep_q_ff <= sleep;
			ready_ff <= nxt_ready;
		end
	end

	assign ready = ready_ff;
endmodule // apd_wake_timer

// >>> hdl/apd_power_down_ctrl.sv
// Power-down control of an eight-channel receive front end, with AXI4-Lite registers
// Assumes synchronous pins and the converter clock as the only clock
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "apd_consts.svh"

module apd_power_down_ctrl #(
	parameter int CH_N = `APD_CH_N
) (
	input wire logic clock,
	input wire logic resetn,
	input wire apd_pkg::apd_axil_req_t axil_req,
	output apd_pkg::apd_axil_rsp_t axil_rsp,
	input wire logic all_block_shutdown_pin,
	input wire logic front_amp_sleep_pin,
	input wire logic converter_sleep_pin,
	output logic [CH_N-1:0] input_amp_off,
	output logic [CH_N-1:0] attenuator_gain_off,
	output logic [CH_N-1:0] converter_off,
	output logic reference_off,
	output logic serial_clock_off,
	output logic front_amp_ready,
	output logic converter_ready,
	output logic reload_needed
);
	apd_pkg::apd_ctrl_t ctrl_ff;
	logic [CH_N-1:0] fa_mask_ff;
	logic [CH_N-1:0] cv_mask_ff;
	logic reload_ff;
	logic aw_full_ff;
	logic w_full_ff;
	logic [`APD_ADDR_W-1:0] awaddr_ff;
	logic [`APD_DATA_W-1:0] wdata_ff;
	logic [3:0] wstrb_ff;
	apd_pkg::apd_axil_rsp_t rsp_ff;
	logic [CH_N-1:0] lna_off_ff;
	logic [CH_N-1:0] att_off_ff;
	logic [CH_N-1:0] cv_off_ff;
	logic ref_off_ff;
	logic ser_off_ff;
	logic fa_ready_w;
	logic cv_ready_w;
	logic fa_ready_ff;
	logic cv_ready_ff;

	// Power-down combination
	wire complete_pd = all_block_shutdown_pin | ctrl_ff.front_amp_full_off_bit
		| ctrl_ff.converter_full_off_bit;
	wire fa_partial = front_amp_sleep_pin | ctrl_ff.front_amp_fast_sleep_bit;
	wire cv_partial = converter_sleep_pin | ctrl_ff.converter_fast_sleep_bit;
	wire fa_group_sleep = complete_pd | fa_partial;
	wire cv_group_sleep = complete_pd | cv_partial;
	logic [CH_N-1:0] nxt_lna_off;
	logic [CH_N-1:0] nxt_att_off;
	logic [CH_N-1:0] nxt_cv_off;

	genvar ch;
	generate
		for (ch = 0; ch < CH_N; ch++) begin : g_chan
			assign nxt_lna_off[ch] = fa_group_sleep | ctrl_ff.input_amp_off_bit | fa_mask_ff[ch];
			assign nxt_att_off[ch] = fa_group_sleep | ctrl_ff.attenuator_gain_stage_off_bit
				| fa_mask_ff[ch];
			assign nxt_cv_off[ch] = cv_group_sleep | cv_mask_ff[ch];
		end
	endgenerate

	// References and serial clocks only stop in complete power-down
	wire nxt_ref_off = complete_pd;
	wire nxt_ser_off = complete_pd;

	// Per-group output flops, one edge after the request
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			lna_off_ff <= '0;
		end else begin
			lna_off_ff <= nxt_lna_off;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			att_off_ff <= '0;
		end else begin
			att_off_ff <= nxt_att_off;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cv_off_ff <= '0;
		end else begin
			cv_off_ff <= nxt_cv_off;
		end
	end

	// Only complete power-down stops references and serial clocks
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ref_off_ff <= 1'b0;
		end else begin
			ref_off_ff <= nxt_ref_off;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ser_off_ff <= 1'b0;
		end else begin
			ser_off_ff <= nxt_ser_off;
		end
	end

	// Wake-up timers
	apd_wake_timer #(
		.CNT_W(24),
		.MIN_CYC(24'(`APD_FA_WAKE_CYC)),
		.PCT_EN(1'b1),
		.PCT_DIV(7'(`APD_PCT_DIV))
	) u_fa_wake (
		.clock(clock),
		.resetn(resetn),
		.sleep(fa_group_sleep),
		.ready(fa_ready_w)
	);

	apd_wake_timer #(
		.CNT_W(24),
		.MIN_CYC(24'(`APD_CV_WAKE_CYC)),
		.PCT_EN(1'b0),
		.PCT_DIV(7'(`APD_PCT_DIV))
	) u_cv_wake (
		.clock(clock),
		.resetn(resetn),
		.sleep(cv_group_sleep),
		.ready(cv_ready_w)
	);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fa_ready_ff <= 1'b0;
		end else begin
			fa_ready_ff <= fa_ready_w;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cv_ready_ff <= 1'b0;
		end else begin
			cv_ready_ff <= cv_ready_w;
		end
	end

	// AXI4-Lite write path
	wire aw_hs = axil_req.awvalid & rsp_ff.awready;
	wire w_hs = axil_req.wvalid & rsp_ff.wready;
	wire b_hs = rsp_ff.bvalid & axil_req.bready;
	wire do_write = aw_full_ff & w_full_ff & ~rsp_ff.bvalid;
	wire wr_ctrl = do_write & (awaddr_ff == `APD_OFS_CTRL);
	wire wr_fa_mask = do_write & (awaddr_ff == `APD_OFS_FA_MASK);
	wire wr_cv_mask = do_write & (awaddr_ff == `APD_OFS_CV_MASK);
	wire wr_status = do_write & (awaddr_ff == `APD_OFS_STATUS);
	wire wr_hit = wr_ctrl | wr_fa_mask | wr_cv_mask | wr_status;
	wire lane0 = wstrb_ff[0];
	wire nxt_aw_full = aw_hs | (aw_full_ff & ~do_write);
	wire nxt_w_full = w_hs | (w_full_ff & ~do_write);
	wire nxt_bvalid = do_write | (rsp_ff.bvalid & ~b_hs);
	// Unmapped addresses answer with an error response
	wire [1:0] nxt_bresp = do_write ? (wr_hit ? `APD_RESP_OKAY : `APD_RESP_SLVERR) : rsp_ff.bresp;

	// Register updates
	wire [5:0] nxt_ctrl = (wr_ctrl & lane0) ? wdata_ff[5:0] : ctrl_ff;
	wire [CH_N-1:0] nxt_fa_mask = (wr_fa_mask & lane0) ? wdata_ff[CH_N-1:0] : fa_mask_ff;
	wire [CH_N-1:0] nxt_cv_mask = (wr_cv_mask & lane0) ? wdata_ff[CH_N-1:0] : cv_mask_ff;
	wire reload_clr = wr_status & lane0 & wdata_ff[`APD_ST_RELOAD];
	wire nxt_reload = complete_pd | (reload_ff & ~reload_clr);

	// AXI4-Lite read path
	wire ar_hs = axil_req.arvalid & rsp_ff.arready;
	wire r_hs = rsp_ff.rvalid & axil_req.rready;
	wire rd_ctrl = axil_req.araddr == `APD_OFS_CTRL;
	wire rd_fa_mask = axil_req.araddr == `APD_OFS_FA_MASK;
	wire rd_cv_mask = axil_req.araddr == `APD_OFS_CV_MASK;
	wire rd_status = axil_req.araddr == `APD_OFS_STATUS;
	wire rd_hit = rd_ctrl | rd_fa_mask | rd_cv_mask | rd_status;
	wire [4:0] status_word = {reload_ff, ser_off_ff, ref_off_ff, cv_ready_ff, fa_ready_ff};
	wire [`APD_DATA_W-1:0] rd_word =
		rd_ctrl ? {26'h0, ctrl_ff} :
		rd_fa_mask ? {{(`APD_DATA_W-CH_N){1'b0}}, fa_mask_ff} :
		rd_cv_mask ? {{(`APD_DATA_W-CH_N){1'b0}}, cv_mask_ff} :
		rd_status ? {27'h0, status_word} : 32'h0;
	wire nxt_rvalid = ar_hs | (rsp_ff.rvalid & ~r_hs);
	wire [`APD_DATA_W-1:0] nxt_rdata = ar_hs ? rd_word : rsp_ff.rdata;
	wire [1:0] nxt_rresp = ar_hs ? (rd_hit ? `APD_RESP_OKAY : `APD_RESP_SLVERR) : rsp_ff.rresp;

	// Address and data are held apart until both have arrived
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			aw_full_ff <= 1'b0;
		end else begin
			aw_full_ff <= nxt_aw_full;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			w_full_ff <= 1'b0;
		end else begin
			w_full_ff <= nxt_w_full;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			awaddr_ff <= '0;
		end else if (aw_hs) begin
			awaddr_ff <= axil_req.awaddr;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wdata_ff <= '0;
			wstrb_ff <= 4'h0;
		end else if (w_hs) begin
			wdata_ff <= axil_req.wdata;
			wstrb_ff <= axil_req.wstrb;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff.awready <= ~nxt_aw_full & ~nxt_bvalid;
			rsp_ff.wready <= ~nxt_w_full & ~nxt_bvalid;
			rsp_ff.bvalid <= nxt_bvalid;
			rsp_ff.bresp <= nxt_bresp;
			rsp_ff.arready <= ~nxt_rvalid;
			rsp_ff.rvalid <= nxt_rvalid;
			rsp_ff.rdata <= nxt_rdata;
			rsp_ff.rresp <= nxt_rresp;
		end
	end

	// Software-visible registers
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			ctrl_ff <= `APD_CTRL_RST;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fa_mask_ff <= `APD_MASK_RST;
		end else begin
			fa_mask_ff <= nxt_fa_mask;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			cv_mask_ff <= `APD_MASK_RST;
		end else begin
			cv_mask_ff <= nxt_cv_mask;
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			reload_ff <= 1'b0;
		end else begin
			reload_ff <= nxt_reload;
		end
	end

	// Outputs
	assign axil_rsp = rsp_ff;
	assign input_amp_off = lna_off_ff;
	assign attenuator_gain_off = att_off_ff;
	assign converter_off = cv_off_ff;
	assign reference_off = ref_off_ff;
	assign serial_clock_off = ser_off_ff;
	assign front_amp_ready = fa_ready_ff;
	assign converter_ready = cv_ready_ff;
	assign reload_needed = reload_ff;

endmodule // apd_power_down_ctrl

// >>> bench/apd_pdc_checker.sv
// Port assertions for the power-down control block
// Assumes a bind onto apd_power_down_ctrl
`timescale 1ns/1ps
module apd_pdc_checker #(
	parameter int CH_N = 8
) (
	input wire logic clock,
	input wire logic resetn,
	input wire apd_pkg::apd_axil_req_t axil_req,
	input wire apd_pkg::apd_axil_rsp_t axil_rsp,
	input wire logic all_block_shutdown_pin,
	input wire logic front_amp_sleep_pin,
	input wire logic converter_sleep_pin,
	input wire logic [CH_N-1:0] input_amp_off,
	input wire logic [CH_N-1:0] attenuator_gain_off,
	input wire logic [CH_N-1:0] converter_off,
	input wire logic reference_off,
	input wire logic serial_clock_off,
	input wire logic front_amp_ready,
	input wire logic converter_ready
);
	logic [9:0] fa_gap_ff;
	logic [9:0] cv_gap_ff;
	logic [9:0] nxt_fa_gap;
	logic [9:0] nxt_cv_gap;
	wire all_off = &{input_amp_off, attenuator_gain_off, converter_off, reference_off, serial_clock_off};
	// Cycles since each sleep pin was last high, saturating
	assign nxt_fa_gap = front_amp_sleep_pin ? 10'h0 : fa_gap_ff + {9'h0, ~&fa_gap_ff};
	assign nxt_cv_gap = converter_sleep_pin ? 10'h0 : cv_gap_ff + {9'h0, ~&cv_gap_ff};
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			fa_gap_ff <= 10'h3ff;
			cv_gap_ff <= 10'h3ff;
		end else begin
			fa_gap_ff <= nxt_fa_gap;
			cv_gap_ff <= nxt_cv_gap;
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);
	sequence s_cv_down;
		(&converter_off) ##1 !converter_ready;
	endsequence
	a_global_all_off: assert property (all_block_shutdown_pin |=> all_off)
		else $error("global pin left a group powered");
	a_fa_pin_sleep: assert property (front_amp_sleep_pin |=> &input_amp_off && &attenuator_gain_off)
		else $error("front amp pin did not sleep group");
	a_cv_pin_sleep: assert property (converter_sleep_pin |=> s_cv_down)
		else $error("converter pin did not sleep group");
	a_ref_full_off: assert property (reference_off |-> all_off)
		else $error("references off while a group runs");
	a_ref_ser_pair: assert property (reference_off == serial_clock_off)
		else $error("serial clocks and references differ");
	a_fa_wake_min: assert property ($rose(front_amp_ready) |-> fa_gap_ff >= 10'd500)
		else $error("front amp ready too early");
	a_cv_wake_min: assert property ($rose(converter_ready) |-> cv_gap_ff >= 10'd250)
		else $error("converter ready too early");
	a_rd_answer: assert property (axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid)
		else $error("read answer late");
	a_wr_answer: assert property (axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready
		|-> ##[1:2] axil_rsp.bvalid)
		else $error("write answer late");
endmodule // apd_pdc_checker

// >>> bench/apd_host_model.sv
// Host model: AXI4-Lite master and shutdown pin driver
// Assumes the bench clock, which never stops
`timescale 1ns/1ps
module apd_host_model (
	input wire logic clock,
	output apd_pkg::apd_axil_req_t axil_req,
	input wire apd_pkg::apd_axil_rsp_t axil_rsp,
	output logic [2:0] pins_ff
);
	// Converter clock runs throughout, well before any resume
	initial begin
		axil_req = '0;
		axil_req.bready = 1'b1;
		axil_req.rready = 1'b1;
		axil_req.wstrb = 4'hf;
		pins_ff = 3'h0;
	end
	task automatic pins(input logic [2:0] p);
		@(posedge clock);
		pins_ff <= p;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge clock);
		axil_req.awaddr <= a;
		axil_req.wdata <= d;
		axil_req.awvalid <= 1'b1;
		axil_req.wvalid <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clock);
			if (axil_rsp.awready) axil_req.awvalid <= 1'b0;
			if (axil_rsp.wready) axil_req.wvalid <= 1'b0;
			if (axil_rsp.bvalid) break;
		end
		r = axil_rsp.bresp;
		if (i == 100) begin
			apd_power_down_ctrl_tb_top.num_errors++;
			apd_power_down_ctrl_tb_top.results();
		end
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge clock);
		axil_req.araddr <= a;
		axil_req.arvalid <= 1'b1;
		for (i = 0; i < 100; i++) begin
			@(posedge clock);
			if (axil_rsp.arready) axil_req.arvalid <= 1'b0;
			if (axil_rsp.rvalid) break;
		end
		d = axil_rsp.rdata;
		r = axil_rsp.rresp;
		if (i == 100) begin
			apd_power_down_ctrl_tb_top.num_errors++;
			apd_power_down_ctrl_tb_top.results();
		end
	endtask
endmodule // apd_host_model

// >>> bench/apd_power_down_ctrl_tb_top.sv
// Self-checking bench for the power-down control block
// Assumes the host model drives bus and pins
`timescale 1ns/1ps
module apd_power_down_ctrl_tb_top;
	logic clock;
	logic resetn;
	apd_pkg::apd_axil_req_t axil_req;
	apd_pkg::apd_axil_rsp_t axil_rsp;
	logic [2:0] pins;
	logic [7:0] ia_off, ag_off, cv_off;
	logic ref_off, ser_off, fa_rdy, cv_rdy, reload;
	logic [1:0] resp;
	logic [31:0] rdat;
	int num_errors = 0;
	int n_compared = 0;
	wire [31:0] outs = {6'h0, ia_off, ag_off, cv_off, ref_off, ser_off};
	logic [31:0] exp_tab [9] = '{32'h3fffc00, 32'h3ffffff, 32'h3fc, 32'h3ffffff, 32'h3fc00, 32'h3fc0000,
		32'h3ffffff, 32'h3fffc00, 32'h3fc};
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	apd_host_model apd_host_model_inst (.clock(clock), .axil_req(axil_req), .axil_rsp(axil_rsp), .pins_ff(pins));
	apd_power_down_ctrl apd_power_down_ctrl_inst (.clock(clock), .resetn(resetn), .axil_req(axil_req),
		.axil_rsp(axil_rsp), .all_block_shutdown_pin(pins[2]), .front_amp_sleep_pin(pins[1]),
		.converter_sleep_pin(pins[0]), .input_amp_off(ia_off), .attenuator_gain_off(ag_off),
		.converter_off(cv_off), .reference_off(ref_off), .serial_clock_off(ser_off),
		.front_amp_ready(fa_rdy), .converter_ready(cv_rdy), .reload_needed(reload));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic wake(input bit cv, input int slp, input int lo, input int hi);
		int n;
		apd_host_model_inst.pins(cv ? 3'h1 : 3'h2);
		repeat (slp) @(posedge clock);
		apd_host_model_inst.pins(3'h0);
		for (n = 0; n < hi + 20 && (cv ? cv_rdy : fa_rdy) !== 1'b1; n++) @(posedge clock);
		chk("wake", 32'(n >= lo && n <= hi), 32'h1);
	endtask
	initial begin
		resetn = 1'b0;
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		repeat (4) @(posedge clock);
		chk("outs", outs, 32'h0);
		for (int i = 0; i < 3; i++) begin
			apd_host_model_inst.rd(12'(4 * i), rdat, resp);
			chk("reg", rdat, 32'h0);
		end
		apd_host_model_inst.rd(12'h100, rdat, resp);
		chk("unmapped", {rdat[29:0], resp}, 32'h2);
		$display("test registers done");
		for (int i = 0; i < 9; i++) begin
			if (i < 6) apd_host_model_inst.wr(12'h0, 32'h1 << i, resp);
			else apd_host_model_inst.pins(3'h4 >> (i - 6));
			repeat (3) @(posedge clock);
			chk("group", outs, exp_tab[i]);
			apd_host_model_inst.wr(12'h0, 32'h0, resp);
			apd_host_model_inst.pins(3'h0);
		end
		apd_host_model_inst.rd(12'h00c, rdat, resp);
		chk("reload", 32'(rdat[4]), 32'h1);
		apd_host_model_inst.wr(12'h00c, 32'h10, resp);
		repeat (2) @(posedge clock);
		chk("reload", 32'(reload), 32'h0);
		apd_host_model_inst.wr(12'h8, 32'h0f, resp);
		apd_host_model_inst.wr(12'h4, 32'h81, resp);
		repeat (3) @(posedge clock);
		chk("masks", {16'h0, ia_off, cv_off}, 32'h810f);
		apd_host_model_inst.pins(3'h1);
		repeat (3) @(posedge clock);
		chk("prio", 32'(cv_off), 32'hff);
		apd_host_model_inst.pins(3'h0);
		apd_host_model_inst.wr(12'h8, 32'h0, resp);
		apd_host_model_inst.wr(12'h4, 32'h0, resp);
		apd_host_model_inst.wr(12'h010, 32'h1, resp);
		chk("bad wr", 32'(resp), 32'h2);
		$display("test pins and masks done");
		wake(1'b0, 100, 500, 506);
		wake(1'b0, 60000, 598, 608);
		wake(1'b1, 100, 250, 256);
		$display("test wake done");
		results();
	end
	initial begin
		repeat (100000) @(posedge clock);
		num_errors++;
		results();
	end
endmodule // apd_power_down_ctrl_tb_top
bind apd_power_down_ctrl apd_pdc_checker #(.CH_N(CH_N)) apd_pdc_checker_inst (.clock(clock), .resetn(resetn),
	.axil_req(axil_req), .axil_rsp(axil_rsp), .all_block_shutdown_pin(all_block_shutdown_pin),
	.front_amp_sleep_pin(front_amp_sleep_pin), .converter_sleep_pin(converter_sleep_pin),
	.input_amp_off(input_amp_off), .attenuator_gain_off(attenuator_gain_off), .converter_off(converter_off),
	.reference_off(reference_off), .serial_clock_off(serial_clock_off), .front_amp_ready(front_amp_ready),
	.converter_ready(converter_ready));
